/* core/cer_exc_unit.sv */
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cer_consts.svh"

module cer_exc_unit (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_ip_i,
    input wire logic [31:0] instr_next_ip_i,
    input wire logic instr_float_i,
    input wire logic instr_nowait_i,
    input wire logic instr_trap_i,
    input wire logic [7:0] trap_vector_i,
    input wire logic mem_valid_i,
    input wire logic [31:0] mem_addr_i,
    input wire cer_pkg::cer_optype_t mem_type_i,
    input wire cer_pkg::cer_seg_t mem_seg_i,
    input wire logic mem_implicit_i,
    input wire logic opsize32_i,
    input wire logic [1:0] current_privilege_level_i,
    input wire logic alignment_check_flag_i,
    input wire logic fpu_err_i,
    input wire logic [31:0] fpu_err_ip_i,
    input wire logic mc_err_i,
    input wire logic mc_ip_related_i,
    input wire logic [31:0] mc_ip_i,
    input wire logic maskable_interrupt_request_i,
    input wire logic [7:0] int_vector_i,
    input wire logic int_enable_flag_i,
    input wire logic commit_idle_i,
    input wire logic [31:0] resume_ip_i,
    output logic instr_block_o,
    output logic int_ack_o,
    output logic exc_valid_o,
    output logic [7:0] exc_vector_o,
    output logic exc_push_code_o,
    output logic [31:0] exc_code_o,
    output logic [31:0] exc_ip_o,
    output logic exc_abort_o,
    output logic float_error_signal_o,
    output logic shutdown_o,
    output logic irq_o
);
    import cer_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [1:0] ctrl;
        logic [`CER_IRQ_W-1:0] stat;
        logic [`CER_IRQ_W-1:0] mask;
        logic [2:0] mc;
        logic fpu_flag;
        logic fpu_pend;
        logic [31:0] fpu_ip;
        logic req_s1;
        logic req_s2;
        logic ev;
        logic [7:0] vec;
        logic push;
        logic [31:0] code;
        logic [31:0] ip;
        logic abort;
        logic ferr;
        logic iack;
        logic int_hold;
    } cer_state_t;

    cer_state_t s_q;
    cer_state_t s_d;

    // ****************************************
    // Alignment decode
    // ****************************************
    // Returns the low address bits that must be zero
    function automatic logic [2:0] cer_align_mask(input cer_optype_t t, input logic big);
        logic [2:0] m;
        m = 3'h0;
        case (t)
            CER_T_WORD, CER_T_SEL, CER_T_FAR32: m = 3'h1;
            CER_T_DWORD, CER_T_SREAL, CER_T_FAR48, CER_T_PTR32: m = 3'h3;
            CER_T_DREAL, CER_T_XREAL: m = 3'h7;
            CER_T_TBLREG: m = 3'h3;
            CER_T_ENV, CER_T_FSAVE, CER_T_BITSTR: m = big ? 3'h3 : 3'h1;
            default: m = 3'h0;
        endcase
        return m;
    endfunction : cer_align_mask

    logic bus_hit;
    logic bus_wr;
    logic align_on;
    logic align_bad;
    logic fpu_wait;
    logic fpu_hit;
    logic trap_hit;
    logic int_hit;
    logic [`CER_IRQ_W-1:0] ev_set;
    logic [`CER_IRQ_W-1:0] w1c;

    // ****************************************
    // Event decode
    // ****************************************
    always_comb begin
        bus_hit = wb_cyc_i && wb_stb_i && !s_q.ack;
        bus_wr = bus_hit && wb_we_i;
        align_on = s_q.ctrl[`CER_CTRL_AM] && alignment_check_flag_i
            && (current_privilege_level_i == 2'h3);
        // data and stack only; no implicit
        align_bad = instr_valid_i && mem_valid_i && align_on && !mem_implicit_i
            && (mem_seg_i == CER_SEG_DATA || mem_seg_i == CER_SEG_STACK)
            && ((mem_addr_i[2:0] & cer_align_mask(mem_type_i, opsize32_i)) != 3'h0);
        fpu_wait = instr_valid_i && instr_float_i && !instr_nowait_i;
        fpu_hit = fpu_wait && s_q.fpu_pend && !align_bad;
        trap_hit = instr_valid_i && instr_trap_i && !align_bad && !fpu_hit
            && (trap_vector_i >= `CER_VEC_USER_LO);
        int_hit = s_q.req_s2 && int_enable_flag_i && commit_idle_i && !instr_valid_i
            && (int_vector_i >= `CER_VEC_USER_LO) && !s_q.int_hold;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.ack = bus_hit;
        s_d.ev = 1'b0;
        s_d.abort = 1'b0;
        s_d.ferr = 1'b0;
        s_d.iack = 1'b0;
        s_d.req_s1 = maskable_interrupt_request_i;
        s_d.req_s2 = s_q.req_s1;
        ev_set = '0;
        w1c = '0;
        // The controller drops its line only after seeing the acknowledge and the
        // line takes two more edges to cross, so a taken request stays blocked
        // until the synchronised line falls; otherwise it would be taken twice
        if (!s_q.req_s2) begin
            s_d.int_hold = 1'b0;
        end

        // ****************************************
        // Register read
        // ****************************************
        // Register reads answer one cycle after the strobe; zero otherwise
        s_d.rdata = 32'h0000_0000;
        if (bus_hit && !wb_we_i) begin
            case (wb_adr_i)
                `CER_OFF_CTRL: s_d.rdata = {30'h0, s_q.ctrl};
                `CER_OFF_IRQ_STAT: s_d.rdata = {27'h0, s_q.stat};
                `CER_OFF_IRQ_MASK: s_d.rdata = {27'h0, s_q.mask};
                `CER_OFF_MC_STATUS: s_d.rdata = {29'h0, s_q.mc};
                `CER_OFF_FPU_STAT: s_d.rdata = {30'h0, s_q.fpu_pend, s_q.fpu_flag};
                `CER_OFF_FPU_IP: s_d.rdata = s_q.fpu_ip;
                `CER_OFF_LAST_VEC: s_d.rdata = {23'h0, s_q.push, s_q.vec};
                `CER_OFF_LAST_IP: s_d.rdata = s_q.ip;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // ****************************************
        // Register write
        // ****************************************
        // Only the low byte lane carries control bits
        if (bus_wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                `CER_OFF_CTRL: s_d.ctrl = wb_dat_i[1:0];
                `CER_OFF_IRQ_MASK: s_d.mask = wb_dat_i[`CER_IRQ_W-1:0];
                `CER_OFF_IRQ_STAT: w1c = wb_dat_i[`CER_IRQ_W-1:0];
                `CER_OFF_FPU_STAT: begin
                    if (wb_dat_i[0]) begin
                        s_d.fpu_flag = 1'b0;
                    end
                end
                `CER_OFF_MC_STATUS: begin
                    if (wb_dat_i[`CER_MC_INPROG]) begin
                        s_d.mc[`CER_MC_INPROG] = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // ****************************************
        // Float error capture
        // ****************************************
        // flag and pending set in the same cycle, except in shutdown, where pending keeps its value
        if (fpu_err_i) begin
            s_d.fpu_flag = 1'b1;
            s_d.fpu_pend = 1'b1;
            s_d.fpu_ip = fpu_err_ip_i;
        end

        // ****************************************
        // Exception priority
        // ****************************************
        // Machine check, then alignment, then float, then traps and requests
        if (s_q.mc[`CER_MC_SHUT]) begin
            // Shutdown is left only through reset
            s_d.fpu_pend = s_q.fpu_pend;
        end else if (mc_err_i) begin
            if (s_q.ctrl[`CER_CTRL_MCE]) begin
                s_d.ev = 1'b1;
                s_d.abort = 1'b1;
                s_d.vec = `CER_VEC_MC;
                s_d.push = 1'b0;
                s_d.code = 32'h0000_0000;
                s_d.ip = mc_ip_i;
                s_d.mc[`CER_MC_IPV] = mc_ip_related_i;
                s_d.mc[`CER_MC_INPROG] = 1'b1;
                ev_set[`CER_IRQ_MC] = 1'b1;
            end else begin
                s_d.mc[`CER_MC_SHUT] = 1'b1;
                ev_set[`CER_IRQ_SHUT] = 1'b1;
            end
        end else if (align_bad) begin
            // block it and point at it
            s_d.ev = 1'b1;
            s_d.vec = `CER_VEC_ALIGN;
            s_d.push = 1'b1;
            s_d.code = `CER_ALIGN_CODE;
            s_d.ip = instr_ip_i;
            ev_set[`CER_IRQ_ALIGN] = 1'b1;
        end else if (fpu_hit) begin
            s_d.ferr = 1'b1;
            s_d.fpu_pend = fpu_err_i;
            s_d.ev = 1'b1;
            s_d.vec = `CER_VEC_FPU;
            s_d.push = 1'b0;
            s_d.code = 32'h0000_0000;
            s_d.ip = instr_ip_i;
            ev_set[`CER_IRQ_FPU] = 1'b1;
        end else if (trap_hit || int_hit) begin
            s_d.ev = 1'b1;
            s_d.vec = trap_hit ? trap_vector_i : int_vector_i;
            s_d.push = 1'b0;
            s_d.code = 32'h0000_0000;
            s_d.ip = trap_hit ? instr_next_ip_i : resume_ip_i;
            s_d.iack = int_hit;
            if (int_hit) begin
                s_d.int_hold = 1'b1;
            end
            ev_set[`CER_IRQ_USER] = 1'b1;
        end

        // ****************************************
        // Status bits
        // ****************************************
        // Hardware set wins over a software clear
        for (int i = 0; i < `CER_IRQ_W; i++) begin
            s_d.stat[i] = ev_set[i] | (s_q.stat[i] & ~w1c[i]);
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
            s_q.ctrl <= `CER_CTRL_RST;
            s_q.mask <= `CER_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    // The core must not retire an instruction this flags
    assign instr_block_o = !s_q.mc[`CER_MC_SHUT] && !mc_err_i && (align_bad || fpu_hit);
    assign int_ack_o = s_q.iack;
    assign exc_valid_o = s_q.ev;
    assign exc_vector_o = s_q.vec;
    assign exc_push_code_o = s_q.push;
    assign exc_code_o = s_q.code;
    assign exc_ip_o = s_q.ip;
    assign exc_abort_o = s_q.abort;
    assign float_error_signal_o = s_q.ferr;
    assign shutdown_o = s_q.mc[`CER_MC_SHUT];
    assign irq_o = |(s_q.stat & s_q.mask);

endmodule : cer_exc_unit

`default_nettype wire

/* core/cer_consts.svh */
`ifndef CER_CONSTS_SVH
`define CER_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CER_OFF_CTRL 8'h00
`define CER_OFF_IRQ_STAT 8'h04
`define CER_OFF_IRQ_MASK 8'h08
`define CER_OFF_MC_STATUS 8'h0C
`define CER_OFF_FPU_STAT 8'h10
`define CER_OFF_FPU_IP 8'h14
`define CER_OFF_LAST_VEC 8'h18
`define CER_OFF_LAST_IP 8'h1C

// ****************************************
// Field positions
// ****************************************
`define CER_CTRL_AM 0
`define CER_CTRL_MCE 1
`define CER_MC_IPV 0
`define CER_MC_INPROG 1
`define CER_MC_SHUT 2
`define CER_IRQ_FPU 0
`define CER_IRQ_ALIGN 1
`define CER_IRQ_MC 2
`define CER_IRQ_SHUT 3
`define CER_IRQ_USER 4
`define CER_IRQ_W 5

// ****************************************
// Reset values and vectors
// ****************************************
`define CER_CTRL_RST 2'h0
`define CER_MASK_RST 5'h00
`define CER_VEC_FPU 8'h10
`define CER_VEC_ALIGN 8'h11
`define CER_VEC_MC 8'h12
`define CER_VEC_USER_LO 8'h20
`define CER_ALIGN_CODE 32'h0000_0000

`endif

/* core/cer_pkg.sv */
package cer_pkg;

    // Operand kinds seen by the alignment checker
    typedef enum logic [3:0] {
        CER_T_BYTE,
        CER_T_WORD,
        CER_T_DWORD,
        CER_T_SREAL,
        CER_T_DREAL,
        CER_T_XREAL,
        CER_T_SEL,
        CER_T_FAR32,
        CER_T_FAR48,
        CER_T_PTR32,
        CER_T_TBLREG,
        CER_T_ENV,
        CER_T_FSAVE,
        CER_T_BITSTR
    } cer_optype_t;

    // Segment classes of a reference
    typedef enum logic [1:0] {
        CER_SEG_DATA,
        CER_SEG_STACK,
        CER_SEG_CODE,
        CER_SEG_SYS
    } cer_seg_t;

endpackage : cer_pkg

/* tb/cer_exc_unit_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Exception checks
// ********
module cer_exc_chk (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [31:0] instr_ip_i,
    input wire cer_pkg::cer_seg_t mem_seg_i,
    input wire logic mem_implicit_i,
    input wire logic [1:0] current_privilege_level_i,
    input wire logic alignment_check_flag_i,
    input wire logic commit_idle_i,
    input wire logic [31:0] resume_ip_i,
    input wire logic instr_block_o,
    input wire logic int_ack_o,
    input wire logic exc_valid_o,
    input wire logic [7:0] exc_vector_o,
    input wire logic exc_push_code_o,
    input wire logic [31:0] exc_code_o,
    input wire logic [31:0] exc_ip_o,
    input wire logic exc_abort_o,
    input wire logic float_error_signal_o
);
    import cer_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic fp;
    logic al;
    assign fp = exc_valid_o && exc_vector_o == 8'h10;
    assign al = exc_valid_o && exc_vector_o == 8'h11;
    property p_fp_code; fp |-> !exc_push_code_o && float_error_signal_o; endproperty
    a_fp_code: assert property (p_fp_code) else $error("float code");
    property p_fp_ip; fp |-> exc_ip_o == $past(instr_ip_i); endproperty
    a_fp_ip: assert property (p_fp_ip) else $error("float ip");
    property p_al_en;
        al |-> $past(current_privilege_level_i) == 2'h3 && $past(alignment_check_flag_i)
            && !$past(mem_implicit_i);
    endproperty
    a_al_en: assert property (p_al_en) else $error("align enable");
    property p_al_seg; al |-> $past(mem_seg_i) inside {CER_SEG_DATA, CER_SEG_STACK}; endproperty
    a_al_seg: assert property (p_al_seg) else $error("align seg");
    property p_al_code; al |-> exc_push_code_o && exc_code_o == 32'h0; endproperty
    a_al_code: assert property (p_al_code) else $error("align code");
    property p_al_ip; al |-> exc_ip_o == $past(instr_ip_i) && $past(instr_block_o); endproperty
    a_al_ip: assert property (p_al_ip) else $error("align ip");
    property p_mc; exc_valid_o && exc_vector_o == 8'h12 |-> exc_abort_o && !exc_push_code_o;
    endproperty
    a_mc: assert property (p_mc) else $error("mc abort");
    property p_int;
        $rose(int_ack_o) |-> exc_valid_o && $past(commit_idle_i) && exc_ip_o == $past(resume_ip_i);
    endproperty
    a_int: assert property (p_int) else $error("int commit");
    c_al: cover property (al);
    c_fp: cover property (fp);
    c_int: cover property (int_ack_o);
endmodule : cer_exc_chk
bind cer_exc_unit cer_exc_chk u_cer_exc_chk (.*);
`default_nettype wire

/* tb/cer_intc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// Interrupt controller
// ********
module cer_intc_model (
    input wire logic clock_i,
    input wire logic raise_i,
    input wire logic [7:0] vec_i,
    input wire logic int_ack_i,
    output logic maskable_interrupt_request_o,
    output logic [7:0] int_vector_o
);
    logic [7:0] vec_q = 8'h00;
    logic req_q = 1'b0;
    always @(posedge clock_i) begin
        if (raise_i) begin
            req_q <= 1'b1;
            vec_q <= vec_i;
        end else if (int_ack_i) begin
            req_q <= 1'b0;
        end
    end
    // Released bus shows no stale vector
    assign int_vector_o = req_q ? vec_q : ~vec_q;
    assign maskable_interrupt_request_o = req_q;
endmodule : cer_intc_model
`default_nettype wire

/* tb/cer_exc_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cer_exc_unit_tb;
    import cer_pkg::*;
    logic clock_i = '0, rst_b_i = '0, wb_cyc_i = '0, wb_we_i = '0, instr_valid_i = '0;
    logic instr_float_i = '0, instr_nowait_i = '0, instr_trap_i = '0, mem_valid_i = '0;
    logic mem_implicit_i = '0, opsize32_i = '0, alignment_check_flag_i = '0, fpu_err_i = '0;
    logic mc_err_i = '0, mc_ip_related_i = '0, int_enable_flag_i = '0, commit_idle_i = '0;
    logic raise = '0, f, wb_ack_o, maskable_interrupt_request_i, instr_block_o, int_ack_o;
    logic exc_valid_o, exc_push_code_o, exc_abort_o, float_error_signal_o, shutdown_o, irq_o;
    logic [1:0] current_privilege_level_i = '0;
    logic fa = '0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [7:0] wb_adr_i = '0, trap_vector_i = '0, rv = '0, int_vector_i, exc_vector_o;
    logic [31:0] wb_dat_i = '0, instr_ip_i = '0, instr_next_ip_i = '0, mem_addr_i = '0;
    logic [31:0] fpu_err_ip_i = '0, mc_ip_i = '0, resume_ip_i = '0;
    logic [31:0] wb_dat_o, exc_code_o, exc_ip_o, k, a;
    cer_optype_t mem_type_i = CER_T_BYTE, t;
    cer_seg_t mem_seg_i = CER_SEG_DATA;
    logic [72:0] eq[$];
    logic [63:0] rq[$], r;
    int fail_count = 0, check_count = 0, seed = 32'hCD9A2885, d;
    wire logic wb_stb_i = wb_cyc_i;
    always #2.5 clock_i = ~clock_i;
    cer_intc_model u_cer_intc_model (.clock_i(clock_i), .raise_i(raise), .vec_i(rv),
        .int_ack_i(int_ack_o), .maskable_interrupt_request_o(maskable_interrupt_request_i),
        .int_vector_o(int_vector_i));
    cer_exc_unit u_cer_exc_unit (.*);
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [72:0] g, input logic [72:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask : chk
    task automatic complete_run;
        fail_count += eq.size() + rq.size();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic wt(ref logic s);
        int m = 0;
        do begin
            @(posedge clock_i);
            m++;
        end while (s !== 1'b1 && m < 40);
        if (m >= 40) begin
            fail_count++;
            complete_run();
        end
    endtask : wt
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= ad;
        wb_dat_i <= dt;
        wt(wb_ack_o);
        wb_cyc_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
        rq.push_back({m, e});
        wb(1'b0, ad, 32'h0);
    endtask : rd
    // Kind bits: float, no-wait, trap, memory operand
    task automatic ins(input logic [31:0] p, input logic [3:0] c, input logic b);
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        instr_ip_i <= p;
        instr_next_ip_i <= p + 32'h4;
        {instr_float_i, instr_nowait_i, instr_trap_i, mem_valid_i} <= c;
        #1;
        if (c[3] | c[0]) chk(73'(instr_block_o), 73'(b));
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
    endtask : ins
    function automatic int dv(cer_optype_t y, logic s);
        case (y)
            CER_T_BYTE: return 1;
            CER_T_WORD, CER_T_SEL, CER_T_FAR32: return 2;
            CER_T_DREAL, CER_T_XREAL: return 8;
            CER_T_ENV, CER_T_FSAVE, CER_T_BITSTR: return s ? 4 : 2;
            default: return 4;
        endcase
    endfunction : dv
    // ********
    // Result monitor
    // ********
    always @(posedge clock_i) begin
        if (exc_valid_o === 1'b1) begin
            if (eq.size() == 0) chk(73'h1, 73'h0);
            else chk({exc_vector_o, exc_push_code_o, exc_push_code_o ? exc_code_o : 32'h0,
                exc_ip_o}, eq.pop_front());
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
            r = rq.pop_front();
            chk(73'(wb_dat_o & r[63:32]), 73'(r[31:0]));
        end
    end
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(8'h00, 32'hFFFFFFFF, 32'h0);
        rd(8'h08, 32'hFFFFFFFF, 32'h0);
        rd(8'hFC, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, 8'h08, 32'h1F);
        wb(1'b1, 8'h00, 32'h3);
        for (int i = 0; i < 60; i++) begin
            if (i == 50) wb(1'b1, 8'h00, 32'h2);
            k = $random(seed);
            a = $random(seed);
            t = cer_optype_t'(k[3:0] % 4'hE);
            d = dv(t, k[7]);
            mem_type_i <= t;
            mem_addr_i <= a;
            mem_seg_i <= cer_seg_t'(k[5:4]);
            mem_implicit_i <= k[6] & k[12];
            opsize32_i <= k[7];
            current_privilege_level_i <= k[10] ? 2'h3 : k[9:8];
            alignment_check_flag_i <= k[11] | k[13];
            f = (a[3:0] & (d[3:0] - 4'h1)) != 4'h0 && !k[5] && !(k[6] & k[12]) && i < 50;
            f = f && (k[10] || k[9:8] == 2'h3) && (k[11] | k[13]);
            if (f) eq.push_back({8'h11, 1'b1, 32'h0, k});
            fa = fa | f;
            ins(k, 4'h1, f);
        end
        fpu_err_ip_i <= 32'h1230;
        fpu_err_i <= 1'b1;
        @(posedge clock_i);
        fpu_err_i <= 1'b0;
        rd(8'h10, 32'h3, 32'h3);
        ins(32'h100, 4'hC, 1'b0);
        eq.push_back({8'h10, 1'b0, 32'h0, 32'h104});
        ins(32'h104, 4'h8, 1'b1);
        rd(8'h14, 32'hFFFFFFFF, 32'h1230);
        rd(8'h04, 32'h3, {30'h0, fa, 1'b1});
        #1 chk(73'(irq_o), 73'h1);
        wb(1'b1, 8'h08, 32'h0);
        #1 chk(73'(irq_o), 73'h0);
        wb(1'b1, 8'h08, 32'h1F);
        wb(1'b1, 8'h04, 32'h1F);
        #1 chk(73'(irq_o), 73'h0);
        @(posedge clock_i);
        for (int i = 0; i < 8; i++) begin
            k = $random(seed);
            k[7:0] = (i == 0) ? 8'h1F : (i == 1) ? 8'h20 : k[7:0];
            trap_vector_i <= k[7:0];
            if (k[7:0] > 8'h1F) eq.push_back({k[7:0], 1'b0, 32'h0, k + 32'h4});
            ins(k, 4'h2, 1'b0);
        end
        resume_ip_i <= 32'h2000;
        int_enable_flag_i <= 1'b1;
        rv <= k[7:0] | 8'h20;
        raise <= 1'b1;
        @(posedge clock_i);
        raise <= 1'b0;
        repeat (8) @(posedge clock_i);
        eq.push_back({rv, 1'b0, 32'h0, 32'h2000});
        commit_idle_i <= 1'b1;
        wt(int_ack_o);
        int_enable_flag_i <= 1'b0;
        mc_ip_i <= 32'h3000;
        mc_ip_related_i <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            eq.push_back({8'h12, 1'b0, 32'h0, 32'h3000});
            mc_err_i <= 1'b1;
            @(posedge clock_i);
            mc_err_i <= 1'b0;
            rd(8'h0C, 32'h1, {31'h0, i == 0});
            wb(1'b1, 8'h0C, 32'h2);
            mc_ip_related_i <= 1'b0;
        end
        wb(1'b1, 8'h00, 32'h0);
        mc_err_i <= 1'b1;
        @(posedge clock_i);
        mc_err_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk(73'(shutdown_o), 73'h1);
        complete_run();
    end
endmodule : cer_exc_unit_tb
`default_nettype wire
